// ---- piw_irq.sv ----
// Interrupt flags, vectoring and wake-up for serial, two-wire, EEPROM and multi-function sources
// Assumes core pulses vec_ack when it takes a vector and pushes the program counter
`timescale 1ns/100ps
module piw_irq
	import piw_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       arst_n,
	input  wire logic [5:0] ser_cond,
	input  wire logic       two_wire_event,
	input  wire logic       eeprom_done,
	input  wire logic       multi_event,
	input  wire logic       global_irq_set,
	input  wire logic       global_irq_clr,
	input  wire logic [3:0] src_enable,
	input  wire logic [3:0] flag_set,
	input  wire logic [3:0] flag_clr,
	input  wire logic       stack_full,
	input  wire logic       sleep_mode,
	input  wire logic       vec_ack,
	input  wire logic       return_with_enable_instr,
	input  wire logic       plain_return_instr,
	output logic            ser_irq_n,
	output logic            vec_req,
	output logic [7:0]      vec_addr,
	output logic            push_pc,
	output logic            wake_up,
	output logic [3:0]      irq_flags,
	output logic            global_irq_enable
);
	typedef struct packed {
		logic [2:0]  ser_sync;
		logic        ser_prev;
		logic        ser_pulse_n;
		logic [3:0]  flags;
		logic        gie;
		logic [1:0]  src;
		logic [7:0]  vec;
		logic        wake;
		piw_state_e  state;
	} piw_s;

	piw_s st_reg;
	piw_s st_next;
	logic [3:0] pend;
	logic [3:0] rise_set;
	logic [1:0] win;
	logic       any_pend;

	function automatic logic [7:0] vec_of(input logic [1:0] s);
		case (s)
			2'd0:    vec_of = VEC_SERIAL;
			2'd1:    vec_of = VEC_TWO_WIRE;
			2'd2:    vec_of = VEC_EEPROM;
			default: vec_of = VEC_MULTI;
		endcase
	endfunction

	always_comb
	begin
		st_next = st_reg;
		// Peripheral pulses arrive from logic on this clock; the serial line is still synchronised
		st_next.ser_sync = {st_reg.ser_sync[1:0], ~(|ser_cond)}; // R1
		st_next.ser_pulse_n = 1'b1;
		if (st_reg.ser_sync[2] == st_reg.ser_sync[1])
		begin
			st_next.ser_prev = st_reg.ser_sync[2];
			if (st_reg.ser_prev && !st_reg.ser_sync[2])
				st_next.ser_pulse_n = 1'b0; // R2
		end
		rise_set = 4'h0;
		rise_set[SRC_SERIAL]   = ~st_reg.ser_pulse_n;
		rise_set[SRC_TWO_WIRE] = two_wire_event; // R6
		rise_set[SRC_EEPROM]   = eeprom_done; // R8
		rise_set[SRC_MULTI]    = multi_event;
		rise_set = rise_set | flag_set;
		pend = st_reg.flags & src_enable & {NSRC{st_reg.gie & ~stack_full}}; // R3 R7 R8
		any_pend = |pend;
		// Lowest index wins; one vector at a time
		win = 2'd3;
		for (int i = NSRC - 1; i >= 0; i--)
			if (pend[i])
				win = 2'(i); // R19
		// Clear first, set after: a coincident event is never lost
		st_next.flags = st_reg.flags & ~flag_clr; // R13
		case (st_reg.state)
			PIW_IDLE:
			begin
				if (any_pend)
				begin
					st_next.src = win;
					st_next.vec = vec_of(win);
					st_next.state = PIW_ACK;
				end
			end
			PIW_ACK:
			begin
				if (vec_ack)
				begin
					// Only the taken source's flag clears; other flags and status stay
					st_next.flags[st_reg.src] = 1'b0; // R4 R5 R7 R9 R14
					st_next.gie = 1'b0; // R4 R7 R9
					st_next.state = PIW_IDLE;
				end
				else if (!st_reg.flags[st_reg.src])
					st_next.state = PIW_IDLE; // R3
			end
			default: st_next.state = PIW_IDLE;
		endcase
		st_next.flags = st_next.flags | rise_set;
		if (return_with_enable_instr || global_irq_set)
			st_next.gie = 1'b1; // R16
		else if (global_irq_clr)
			st_next.gie = 1'b0;
		// Plain return leaves the enable alone
		st_next.wake = sleep_mode & |(st_next.flags & ~st_reg.flags); // R10 R11
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_reg.ser_sync    <= SYNC_RST;
			st_reg.ser_prev    <= 1'b1;
			st_reg.ser_pulse_n <= 1'b1;
			st_reg.flags       <= FLAGS_RST;
			st_reg.gie         <= GIE_RST;
			st_reg.src         <= 2'd0;
			st_reg.vec         <= VEC_RST;
			st_reg.wake        <= 1'b0;
			st_reg.state       <= PIW_IDLE;
		end
		else
			st_reg <= st_next;
	end

	// Request withdrawn if global enable dropped meanwhile
	assign vec_req           = (st_reg.state == PIW_ACK) & st_reg.gie & ~stack_full & st_reg.flags[st_reg.src]; // R3
	assign vec_addr          = st_reg.vec;
	assign push_pc           = vec_ack & vec_req; // R15
	assign ser_irq_n         = st_reg.ser_pulse_n;
	assign wake_up           = st_reg.wake;
	assign irq_flags         = st_reg.flags;
	assign global_irq_enable = st_reg.gie;

	logic unused_ret;
	assign unused_ret = plain_return_instr; // R17

	ack_clears_a: assert property (@(posedge mclk) disable iff (!arst_n) // R4
		vec_ack && vec_req && !rise_set[st_reg.src] && !global_irq_set && !return_with_enable_instr
		|=> !irq_flags[$past(st_reg.src)] && !global_irq_enable)
		else $error("service did not clear flag and enable");

	return_with_enable_instr_sets_a: assert property (@(posedge mclk) disable iff (!arst_n)
		return_with_enable_instr |=> global_irq_enable) // R16
		else $error("return with enable left enable low");

	ret_keeps_a: assert property (@(posedge mclk) disable iff (!arst_n)
		plain_return_instr && !return_with_enable_instr && !global_irq_set && !global_irq_clr
		&& !(vec_ack && vec_req) |=> global_irq_enable == $past(global_irq_enable)) // R17
		else $error("plain return changed enable");

	req_gate_a: assert property (@(posedge mclk) disable iff (!arst_n)
		vec_req |-> global_irq_enable && !stack_full && irq_flags[st_reg.src]) // R3
		else $error("vector request without enables");

	flag_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
		irq_flags[SRC_EEPROM] && !flag_clr[SRC_EEPROM] && !(vec_ack && vec_req)
		|=> irq_flags[SRC_EEPROM]) // R13
		else $error("flag dropped without service");

	tw_set_a: assert property (@(posedge mclk) disable iff (!arst_n)
		two_wire_event |=> irq_flags[SRC_TWO_WIRE]) // R6
		else $error("two-wire flag not set");

	ee_set_a: assert property (@(posedge mclk) disable iff (!arst_n)
		eeprom_done |=> irq_flags[SRC_EEPROM]) // R8
		else $error("eeprom flag not set");

	wake_rise_a: assert property (@(posedge mclk) disable iff (!arst_n)
		$past(sleep_mode) && $rose(irq_flags[SRC_TWO_WIRE]) |-> wake_up) // R10
		else $error("no wake on rising flag");

	ser_pulse_a: assert property (@(posedge mclk) disable iff (!arst_n)
		!ser_irq_n |=> ser_irq_n) // R2
		else $error("serial pulse longer than one cycle");

	ser_path_a: assert property (@(posedge mclk) disable iff (!arst_n)
		$rose(|ser_cond) ##1 (|ser_cond) [*3] |-> ##[0:2] !ser_irq_n) // R1
		else $error("serial condition not signalled");

	push_only_a: assert property (@(posedge mclk) disable iff (!arst_n)
		push_pc |=> !push_pc) // R15
		else $error("more than one push per vector");

	prio_ser_a: assert property (@(posedge mclk) disable iff (!arst_n)
		st_reg.state == PIW_IDLE && pend[SRC_SERIAL] |=> vec_addr == VEC_SERIAL) // R19
		else $error("serial request lost priority");

	prio_tw_a: assert property (@(posedge mclk) disable iff (!arst_n)
		st_reg.state == PIW_IDLE && !pend[SRC_SERIAL] && pend[SRC_TWO_WIRE] |=> vec_addr == VEC_TWO_WIRE) // R19
		else $error("two-wire request lost priority");

	prio_ee_a: assert property (@(posedge mclk) disable iff (!arst_n)
		st_reg.state == PIW_IDLE && pend[1:0] == 2'h0 && pend[SRC_EEPROM] |=> vec_addr == VEC_EEPROM) // R19
		else $error("eeprom request lost priority");

	vec_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
		vec_req && !vec_ack |=> $stable(vec_addr)) // R19
		else $error("vector changed while requested");

	gie_drop_a: assert property (@(posedge mclk) disable iff (!arst_n)
		push_pc && !global_irq_set && !return_with_enable_instr |=> !global_irq_enable) // R4
		else $error("global enable kept after service");

	full_block_a: assert property (@(posedge mclk) disable iff (!arst_n)
		stack_full |-> !vec_req) // R3
		else $error("vector requested with stack full");

	gie_block_a: assert property (@(posedge mclk) disable iff (!arst_n)
		!global_irq_enable |-> !vec_req) // R3
		else $error("vector requested with enable low");

	wake_sleep_a: assert property (@(posedge mclk) disable iff (!arst_n)
		!$past(sleep_mode) |-> !wake_up) // R10
		else $error("wake outside sleep");

	wake_cause_a: assert property (@(posedge mclk) disable iff (!arst_n)
		wake_up |-> (irq_flags & ~$past(irq_flags)) != 4'h0) // R11
		else $error("wake without rising flag");

	ser_flag_a: assert property (@(posedge mclk) disable iff (!arst_n)
		!ser_irq_n |=> irq_flags[SRC_SERIAL]) // R1
		else $error("serial pulse did not set flag");

	ack_done_a: assert property (@(posedge mclk) disable iff (!arst_n)
		push_pc |=> st_reg.state == PIW_IDLE) // R19
		else $error("vector not retired after take");

	ee_clear_a: assert property (@(posedge mclk) disable iff (!arst_n) // R9
		push_pc && vec_addr == VEC_EEPROM && !eeprom_done && !flag_set[SRC_EEPROM]
		|=> !irq_flags[SRC_EEPROM])
		else $error("eeprom flag kept after service");

	tw_clear_a: assert property (@(posedge mclk) disable iff (!arst_n) // R7
		push_pc && vec_addr == VEC_TWO_WIRE && !two_wire_event && !flag_set[SRC_TWO_WIRE]
		|=> !irq_flags[SRC_TWO_WIRE])
		else $error("two-wire flag kept after service");

	multi_keep_a: assert property (@(posedge mclk) disable iff (!arst_n) // R14
		push_pc && vec_addr == VEC_MULTI && irq_flags[SRC_EEPROM] && !flag_clr[SRC_EEPROM]
		|=> irq_flags[SRC_EEPROM])
		else $error("group service cleared another flag");

	ser_clear_a: assert property (@(posedge mclk) disable iff (!arst_n) // R4
		push_pc && vec_addr == VEC_SERIAL && ser_irq_n && !flag_set[SRC_SERIAL]
		|=> !irq_flags[SRC_SERIAL])
		else $error("serial flag kept after service");

	idle_quiet_a: assert property (@(posedge mclk) disable iff (!arst_n)
		st_reg.state == PIW_IDLE |-> !vec_req) // R19
		else $error("request without latched source");

	all_set_a: assert property (@(posedge mclk) disable iff (!arst_n)
		irq_flags == 4'hF |=> !wake_up) // R11
		else $error("wake with every flag already high");

	gie_set_a: assert property (@(posedge mclk) disable iff (!arst_n)
		global_irq_set |=> global_irq_enable) // R3
		else $error("software set left enable low");

	gie_clr_a: assert property (@(posedge mclk) disable iff (!arst_n)
		global_irq_clr && !global_irq_set && !return_with_enable_instr |=> !global_irq_enable) // R3
		else $error("software clear left enable high");

	multi_set_a: assert property (@(posedge mclk) disable iff (!arst_n)
		multi_event |=> irq_flags[SRC_MULTI]) // R14
		else $error("group flag not set");

	genvar gi;
	for (gi = 0; gi < NSRC; gi++)
	begin : flag_chk
		set_each_a: assert property (@(posedge mclk) disable iff (!arst_n)
			flag_set[gi] |=> irq_flags[gi]) // R13
			else $error("software set did not set flag");

		clear_each_a: assert property (@(posedge mclk) disable iff (!arst_n)
			flag_clr[gi] && !rise_set[gi] |=> !irq_flags[gi]) // R13
			else $error("software clear did not clear flag");

		hold_each_a: assert property (@(posedge mclk) disable iff (!arst_n)
			irq_flags[gi] && !flag_clr[gi] && !(push_pc && st_reg.src == gi) |=> irq_flags[gi]) // R13
			else $error("flag dropped on its own");

		wake_each_a: assert property (@(posedge mclk) disable iff (!arst_n)
			$past(sleep_mode) && $rose(irq_flags[gi]) |-> wake_up) // R10
			else $error("rising flag did not wake");
	end

	ser_pulse_c: cover property (@(posedge mclk) disable iff (!arst_n)
		!ser_irq_n);
	serial_vec_c: cover property (@(posedge mclk) disable iff (!arst_n)
		push_pc && vec_addr == VEC_SERIAL);
	prio_c: cover property (@(posedge mclk) disable iff (!arst_n)
		st_reg.state == PIW_IDLE && pend[0] && pend[2]);
	wake_c: cover property (@(posedge mclk) disable iff (!arst_n)
		wake_up);
	return_with_enable_instr_c: cover property (@(posedge mclk) disable iff (!arst_n)
		push_pc ##[1:20] return_with_enable_instr);
endmodule

// ---- piw_pkg.sv ----
// Constants for the peripheral interrupt and wake-up block
// Assumes one system clock and peripherals on that clock
//
// Behaviour
// R1 - Serial port request is the OR of six serial port conditions.
// R2 - Serial port condition reaches the interrupt logic as an active-low pulse.
// R3 - Serial vector needs global enable, serial enable, stack not full, condition.
// R4 - Serial service clears serial flag and global enable.
// R5 - Service leaves serial port status flags untouched.
// R6 - Two-wire flag sets on byte done, address match or time-out.
// R7 - Two-wire vector needs both enables, stack not full; service clears flag, global.
// R8 - EEPROM flag sets at erase or write end; vector needs both enables.
// R9 - EEPROM service clears its flag and the global enable.
// R10 - Any flag rising wakes from sleep or idle, enabled or not.
// R11 - Enable bits have no effect on wake-up.
// R12 - Software sets a flag before sleep to suppress its wake-up.
// R13 - Flag holds until serviced or cleared; disabling only blocks service.
// R14 - Multi-function service clears only the group flag, not the source flag.
// R15 - Interrupt entry pushes only the program counter.
// R16 - Return-with-enable returns and sets the global enable.
// R17 - Plain return returns and leaves the global enable unchanged.
// R18 - Service routines should avoid calls; a nearly full stack may overrun.
// R19 - Simultaneous enabled requests are serviced one at a time by fixed priority.
package piw_pkg;
	localparam int         NSRC          = 4;
	localparam int         SRC_SERIAL    = 0;
	localparam int         SRC_TWO_WIRE  = 1;
	localparam int         SRC_EEPROM    = 2;
	localparam int         SRC_MULTI     = 3;
	localparam logic [3:0] FLAGS_RST     = 4'h0;
	localparam logic       GIE_RST       = 1'h0;
	localparam logic [7:0] VEC_SERIAL    = 8'h1C;
	localparam logic [7:0] VEC_TWO_WIRE  = 8'h20;
	localparam logic [7:0] VEC_EEPROM    = 8'h24;
	localparam logic [7:0] VEC_MULTI     = 8'h28;
	localparam logic [7:0] VEC_RST       = 8'h00;
	localparam logic [2:0] SYNC_RST      = 3'h7;
	typedef enum logic [1:0]
	{
		PIW_IDLE = 2'b00,
		PIW_ACK  = 2'b01
	} piw_state_e;
endpackage

// ---- piw_core_model.sv ----
// Core sequencer model: takes vectors, counts program counter pushes
// Assumes vec_req is level until taken; slow adds a wait before each take
`timescale 1ns/100ps
module piw_core_model
(
	input  wire logic mclk,
	input  wire logic arst_n,
	input  wire logic vec_req,
	input  wire logic push_pc,
	input  wire logic slow,
	output logic      vec_ack,
	output int        push_count
);
	logic [1:0] wait_cnt;
	// One take per vector, no nested calls inside a service
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
		begin
			vec_ack <= 1'h0;
			wait_cnt <= 2'h0;
			push_count <= 0;
		end
		else
		begin
			push_count <= push_count + int'(push_pc);
			if (vec_ack)
				vec_ack <= 1'h0;
			else if (vec_req && (!slow || wait_cnt == 2'h3))
				vec_ack <= 1'h1;
			wait_cnt <= (vec_req && !vec_ack) ? wait_cnt + 2'h1 : 2'h0;
		end
endmodule

// ---- peripheral_interrupt_wakeup_logic_tb.sv ----
// Self-checking bench for the interrupt and wake-up block
// Assumes the core model answers vectors; inputs change at falling edges
`timescale 1ns/100ps
module peripheral_interrupt_wakeup_logic_tb;
	import piw_pkg::*;
	logic mclk = 1'h0, arst_n = 1'h0, two_wire_event = 1'h0, eeprom_done = 1'h0;
	logic multi_event = 1'h0, global_irq_set = 1'h0, global_irq_clr = 1'h0, stack_full = 1'h0;
	logic sleep_mode = 1'h0, return_with_enable_instr = 1'h0, plain_return_instr = 1'h0, slow = 1'h0;
	logic [5:0] ser_cond = 6'h00;
	logic [3:0] src_enable = 4'h0, flag_set = 4'h0, flag_clr = 4'h0, old_f, f, c;
	logic ser_irq_n, vec_req, push_pc, wake_up, global_irq_enable, vec_ack;
	logic [7:0] vec_addr;
	logic [3:0] irq_flags;
	int push_count, i, err_count = 0, check_count = 0, seed = 32'hfe14;
	piw_irq dut_u (.mclk(mclk), .arst_n(arst_n), .ser_cond(ser_cond), .two_wire_event(two_wire_event),
		.eeprom_done(eeprom_done), .multi_event(multi_event), .global_irq_set(global_irq_set),
		.global_irq_clr(global_irq_clr), .src_enable(src_enable), .flag_set(flag_set), .flag_clr(flag_clr),
		.stack_full(stack_full), .sleep_mode(sleep_mode), .vec_ack(vec_ack),
		.return_with_enable_instr(return_with_enable_instr), .plain_return_instr(plain_return_instr),
		.ser_irq_n(ser_irq_n), .vec_req(vec_req), .vec_addr(vec_addr), .push_pc(push_pc), .wake_up(wake_up),
		.irq_flags(irq_flags), .global_irq_enable(global_irq_enable));
	piw_core_model core_u (.mclk(mclk), .arst_n(arst_n), .vec_req(vec_req), .push_pc(push_pc), .slow(slow),
		.vec_ack(vec_ack), .push_count(push_count));
	initial forever #5 mclk = ~mclk;
	task automatic tick(int n = 1);
		repeat (n) @(negedge mclk);
	endtask
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		check_count++;
		if (s !== e)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	// Next flags: software set wins over clear
	function automatic logic [3:0] nf(logic [3:0] o, logic [3:0] s, logic [3:0] k);
		return (o & ~k) | s;
	endfunction
	task automatic serve(logic [7:0] v);
		for (i = 0; i < 20 && vec_req !== 1'h1; i++) tick();
		chk("vec_addr", vec_addr, v);
		tick(8);
	endtask
	task automatic gie_on;
		global_irq_set = 1'h1;
		tick();
		global_irq_set = 1'h0;
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Whole run needs a few hundred cycles
	initial
	begin
		#100000;
		err_count++;
		close_out();
	end
	initial
	begin
		tick(16);
		arst_n = 1'h1;
		tick();
		chk("flags_rst", irq_flags, FLAGS_RST);
		src_enable = 4'hF;
		gie_on();
		eeprom_done = 1'h1;
		tick();
		eeprom_done = 1'h0;
		serve(VEC_EEPROM);
		chk("flags", irq_flags, 8'h00);
		chk("gie", global_irq_enable, 8'h00);
		chk("pushes", push_count[7:0], 8'h01);
		{two_wire_event, eeprom_done, multi_event} = 3'h7;
		tick();
		{two_wire_event, eeprom_done, multi_event} = 3'h0;
		stack_full = 1'h1;
		gie_on();
		tick(5);
		chk("req_full", vec_req, 8'h00);
		chk("flags", irq_flags, 8'h0E);
		stack_full = 1'h0;
		slow = 1'h1;
		serve(VEC_TWO_WIRE);
		chk("flags", irq_flags, 8'h0C);
		return_with_enable_instr = 1'h1;
		tick();
		return_with_enable_instr = 1'h0;
		chk("gie_ret", global_irq_enable, 8'h01);
		serve(VEC_EEPROM);
		plain_return_instr = 1'h1;
		tick();
		plain_return_instr = 1'h0;
		tick(4);
		chk("gie_plain", global_irq_enable, 8'h00);
		chk("req_plain", vec_req, 8'h00);
		gie_on();
		serve(VEC_MULTI);
		chk("flags", irq_flags, 8'h00);
		src_enable = 4'h0;
		gie_on();
		two_wire_event = 1'h1;
		tick();
		two_wire_event = 1'h0;
		tick(5);
		chk("req_off", vec_req, 8'h00);
		chk("flag_held", irq_flags, 8'h02);
		flag_clr = 4'hF;
		tick();
		flag_clr = 4'h0;
		// Each serial condition alone; output pulse is only one cycle wide
		for (int b = 0; b < 6; b++)
		begin
			ser_cond = 6'h01 << b;
			for (i = 0; i < 12 && ser_irq_n !== 1'h0; i++) tick();
			chk("ser_irq_n", ser_irq_n, 8'h00);
			ser_cond = 6'h00;
			tick(3);
			chk("ser_flag", irq_flags[0], 8'h01);
			chk("ser_vec", vec_req, 8'h00);
			flag_clr = 4'h1;
			tick();
			flag_clr = 4'h0;
		end
		// Random sets and clears while asleep; a set flag cannot wake again
		global_irq_clr = 1'h1;
		sleep_mode = 1'h1;
		repeat (40)
		begin
			old_f = irq_flags;
			f = 4'($random(seed)) & 4'($random(seed));
			c = 4'($random(seed));
			src_enable = 4'($random(seed));
			flag_set = f;
			flag_clr = c;
			tick();
			{flag_set, flag_clr} = 8'h00;
			chk("flags_rnd", irq_flags, nf(old_f, f, c));
			chk("wake", wake_up, |(nf(old_f, f, c) & ~old_f));
			tick();
			chk("wake_end", wake_up, 8'h00);
		end
		close_out();
	end
endmodule
